/* File: logic/ext_setup_pkg.sv */
// Purpose: Constants and carriers for the parallel and serial extended setup.
// Assumes: One 8-bit register reached through a configuration index.
// Notes: Shared by the register block and its divisor helper.
// How it works
// R1 - Register reachable only in configuration state with index 04H loaded.
// R2 - Register holds 00H after power-up reset.
// R3 - Bits 1:0 pick SPP, EPP+SPP, ECP, or ECP+EPP when printer mode is low.
// R4 - Bits 3:2 pick normal, floppy routing one, routing two, or reserved.
// R5 - Bit 4 sets serial port one divisor: low 13, high 12 with MIDI.
// R6 - Bit 5 sets serial port two divisor: low 13, high 12 with MIDI.
// R7 - Bit 6 picks EPP revision: zero is 1.9, one is 1.7.
// R8 - Bit 7 is reserved and always reads zero.
// R9 - In ECP with EPP, extended control mode 100 gives EPP operation.
// R10 - In either ECP setting, extended control mode 000 gives SPP.
// R11 - ECP settings drive two floppies directly; more needs external decode.
// R12 - MIDI rate 31.25Kbaud from 24 MHz divided by 12, by 16, then by 4.
// R13 - Printer-mode bit high forces printer mode, ignoring the extended field.
// R14 - Writes to bit 7 are discarded so reads stay zero.
package ext_setup_pkg;
  localparam logic [7:0] SETUP_INDEX = 8'h04;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  localparam logic [7:0] SETUP_WMASK = 8'h7f;
  localparam int MODE_LSB = 0;
  localparam int FLOPPY_LSB = 2;
  localparam int PORT1_CLK_BIT = 4;
  localparam int PORT2_CLK_BIT = 5;
  localparam int EPP_REV_BIT = 6;
  localparam logic [3:0] DIV_STD = 4'hd;
  localparam logic [3:0] DIV_MIDI = 4'hc;
  localparam logic [2:0] ECR_SPP = 3'h0;
  localparam logic [2:0] ECR_EPP = 3'h4;

  typedef enum logic [1:0] {
    EXT_SPP, EXT_EPP_SPP, EXT_ECP, EXT_ECP_EPP
  } ext_mode_e;

  typedef enum logic [1:0] {
    FLOPPY_NORMAL, FLOPPY_OPT_ONE, FLOPPY_OPT_TWO, FLOPPY_RSVD
  } floppy_route_e;

  typedef enum logic [2:0] {
    PORT_PRINTER, PORT_SPP, PORT_EPP, PORT_ECP
  } port_op_e;

  typedef struct packed {
    logic epp_revision_select;
    logic port2_clock_select;
    logic port1_clock_select;
    floppy_route_e floppy_route;
    ext_mode_e ext_mode;
  } setup_s;
endpackage

/* File: logic/baud_prescaler.sv */
// Purpose: Baud reference prescaler, divide by 13 or 12.
// Assumes: Reference clock is the core clock.
// Notes: One tick per division period.
`timescale 1ns/1ps
`default_nettype none
module baud_prescaler (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic midi_sel,
  output logic tick
);
  logic [3:0] count_reg;
  logic [3:0] limit;

  assign limit = midi_sel ? ext_setup_pkg::DIV_MIDI : ext_setup_pkg::DIV_STD;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_reg <= 4'h0;
      tick <= 1'b0;
    end else if (count_reg >= limit - 4'h1) begin
      count_reg <= 4'h0;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 4'h1;
      tick <= 1'b0;
    end
  end

  // The period is counted rather than unrolled as a long repetition.
  // A change of the divisor select voids the period in which it falls.
  logic [3:0] gap_reg;
  logic clean_reg;
  logic sel_q_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_reg <= 4'h0;
      clean_reg <= 1'b0;
      sel_q_reg <= 1'b0;
    end else begin
      sel_q_reg <= midi_sel;
      if (tick) begin
        gap_reg <= 4'h1;
      end else if (gap_reg != 4'hf) begin
        gap_reg <= gap_reg + 4'h1;
      end
      if (midi_sel != sel_q_reg) begin
        clean_reg <= 1'b0;
      end else if (tick) begin
        clean_reg <= 1'b1;
      end
    end
  end

  property p_period;
    @(posedge core_clk) disable iff (!reset_n)
      tick && clean_reg && (midi_sel == sel_q_reg) |-> gap_reg == limit;
  endproperty
  a_period: assert property (p_period) // see R5
    else $error("baud tick period wrong");
endmodule
`default_nettype wire

/* File: logic/parallel_serial_ext_setup.sv */
// Purpose: Extended setup register for parallel modes and UART divisors.
// Assumes: Config state and index come from the configuration port logic.
// Notes: Printer-mode bit and ECP mode field come from neighbouring units.
`timescale 1ns/1ps
`default_nettype none
module parallel_serial_ext_setup (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic config_state,
  input wire logic [7:0] config_index_register,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_wdata,
  input wire logic printer_mode,
  input wire logic [2:0] ecr_mode,
  input wire logic ext_four_drive,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  output ext_setup_pkg::setup_s setup,
  output ext_setup_pkg::port_op_e port_op,
  output logic epp_revision_select,
  output logic [3:0] port1_divisor,
  output logic [3:0] port2_divisor,
  output logic port1_baud_tick,
  output logic port2_baud_tick,
  output logic four_drive_needed
);
  // ****************************************************************
  // Register access
  // ****************************************************************
  logic sel;
  logic [7:0] setup_reg;
  logic tick1;
  logic tick2;
  ext_setup_pkg::setup_s cur;
  ext_setup_pkg::port_op_e op_next;

  function automatic logic [3:0] divisor_of(input logic midi);
    divisor_of = midi ? ext_setup_pkg::DIV_MIDI : ext_setup_pkg::DIV_STD;
  endfunction

  assign sel = config_state &&
    (config_index_register == ext_setup_pkg::SETUP_INDEX); // see R1
  assign cur = ext_setup_pkg::setup_s'(setup_reg[6:0]);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      setup_reg <= ext_setup_pkg::SETUP_RESET; // see R2
    end else if (cfg_wr && sel) begin
      // Bit 7 is never stored, so reads of it stay zero.
      setup_reg <= cfg_wdata & ext_setup_pkg::SETUP_WMASK; // see R8 see R14
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd && sel; // see R1
      cfg_rdata <= (cfg_rd && sel) ? {1'b0, setup_reg[6:0]} : 8'h00; // see R8
    end
  end

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  always_comb begin
    op_next = ext_setup_pkg::PORT_SPP;
    if (printer_mode) begin
      op_next = ext_setup_pkg::PORT_PRINTER; // see R13
    end else begin
      unique case (cur.ext_mode) // see R3
        ext_setup_pkg::EXT_SPP: op_next = ext_setup_pkg::PORT_SPP;
        ext_setup_pkg::EXT_EPP_SPP: op_next = ext_setup_pkg::PORT_EPP;
        ext_setup_pkg::EXT_ECP: begin
          op_next = (ecr_mode == ext_setup_pkg::ECR_SPP) ?
            ext_setup_pkg::PORT_SPP : ext_setup_pkg::PORT_ECP; // see R10
        end
        ext_setup_pkg::EXT_ECP_EPP: begin
          if (ecr_mode == ext_setup_pkg::ECR_EPP) begin
            op_next = ext_setup_pkg::PORT_EPP; // see R9
          end else if (ecr_mode == ext_setup_pkg::ECR_SPP) begin
            op_next = ext_setup_pkg::PORT_SPP; // see R10
          end else begin
            op_next = ext_setup_pkg::PORT_ECP;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs to the port, floppy and serial units
  // ****************************************************************
  // Registered outputs lag the register by one cycle; units tolerate this.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      setup <= ext_setup_pkg::setup_s'(ext_setup_pkg::SETUP_RESET[6:0]);
      port_op <= ext_setup_pkg::PORT_SPP;
      epp_revision_select <= 1'b0;
      port1_divisor <= ext_setup_pkg::DIV_STD;
      port2_divisor <= ext_setup_pkg::DIV_STD;
      four_drive_needed <= 1'b0;
    end else begin
      setup <= cur; // see R4
      port_op <= op_next;
      epp_revision_select <= cur.epp_revision_select; // see R7
      port1_divisor <= divisor_of(cur.port1_clock_select); // see R5
      port2_divisor <= divisor_of(cur.port2_clock_select); // see R6
      // Flags an ECP setting without external decode: two drives only.
      four_drive_needed <= cur.ext_mode[1] && !ext_four_drive; // see R11
    end
  end

  // Divide-by-12 ticks feed a divide-by-16 in the UART for MIDI rate.
  baud_prescaler u_pre1 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .midi_sel(cur.port1_clock_select),
    .tick(tick1)
  ); // see R12
  baud_prescaler u_pre2 (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .midi_sel(cur.port2_clock_select),
    .tick(tick2)
  );

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      port1_baud_tick <= 1'b0;
      port2_baud_tick <= 1'b0;
    end else begin
      port1_baud_tick <= tick1;
      port2_baud_tick <= tick2;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_no_write_outside;
    @(posedge core_clk) disable iff (!reset_n)
      !(cfg_wr && sel) |=> $stable(setup_reg);
  endproperty
  a_no_write_outside: assert property (p_no_write_outside) // see R1
    else $error("register changed without selected write");

  property p_bit7_zero;
    @(posedge core_clk) disable iff (!reset_n)
      cfg_rvalid |-> cfg_rdata[7] == 1'b0;
  endproperty
  a_bit7_zero: assert property (p_bit7_zero) // see R8
    else $error("reserved bit read as one");

  property p_write_readback;
    @(posedge core_clk) disable iff (!reset_n)
      cfg_wr && sel ##1 cfg_rd && sel && !cfg_wr |=>
        cfg_rdata == ($past(cfg_wdata, 2) & 8'h7f);
  endproperty
  a_write_readback: assert property (p_write_readback) // see R14
    else $error("readback mismatch");

  property p_printer;
    @(posedge core_clk) disable iff (!reset_n)
      printer_mode |=> port_op == ext_setup_pkg::PORT_PRINTER;
  endproperty
  a_printer: assert property (p_printer) // see R13
    else $error("printer mode not forced");

  property p_epp_via_ecr;
    @(posedge core_clk) disable iff (!reset_n)
      !printer_mode && cur.ext_mode == ext_setup_pkg::EXT_ECP_EPP &&
      ecr_mode == ext_setup_pkg::ECR_EPP |=> port_op == ext_setup_pkg::PORT_EPP;
  endproperty
  a_epp_via_ecr: assert property (p_epp_via_ecr) // see R9
    else $error("epp not entered");

  property p_spp_via_ecr;
    @(posedge core_clk) disable iff (!reset_n)
      !printer_mode && cur.ext_mode[1] && ecr_mode == ext_setup_pkg::ECR_SPP
        |=> port_op == ext_setup_pkg::PORT_SPP;
  endproperty
  a_spp_via_ecr: assert property (p_spp_via_ecr) // see R10
    else $error("spp not entered");

  property p_div1;
    @(posedge core_clk) disable iff (!reset_n)
      ##1 port1_divisor == ($past(setup_reg[4]) ? 4'hc : 4'hd);
  endproperty
  a_div1: assert property (p_div1) // see R5
    else $error("port one divisor wrong");

  property p_div2;
    @(posedge core_clk) disable iff (!reset_n)
      ##1 port2_divisor == ($past(setup_reg[5]) ? 4'hc : 4'hd);
  endproperty
  a_div2: assert property (p_div2) // see R6
    else $error("port two divisor wrong");

  property p_rev;
    @(posedge core_clk) disable iff (!reset_n)
      ##1 epp_revision_select == $past(setup_reg[6]);
  endproperty
  a_rev: assert property (p_rev) // see R7
    else $error("epp revision wrong");

  property p_floppy;
    @(posedge core_clk) disable iff (!reset_n)
      ##1 setup.floppy_route == $past(setup_reg[3:2]);
  endproperty
  a_floppy: assert property (p_floppy) // see R4
    else $error("floppy routing wrong");

  property p_four_drive;
    @(posedge core_clk) disable iff (!reset_n)
      ##1 four_drive_needed == $past(setup_reg[1] && !ext_four_drive);
  endproperty
  a_four_drive: assert property (p_four_drive) // see R11
    else $error("four drive flag wrong");

  property p_base_modes;
    @(posedge core_clk) disable iff (!reset_n)
      !printer_mode && !setup_reg[1] |=> port_op == ($past(setup_reg[0]) ?
        ext_setup_pkg::PORT_EPP : ext_setup_pkg::PORT_SPP);
  endproperty
  a_base_modes: assert property (p_base_modes) // see R3
    else $error("base parallel mode wrong");
endmodule
`default_nettype wire

/* File: bench/parallel_serial_ext_setup_tb.sv */
// Purpose: Self-checking bench for the extended setup register block.
// Assumes: Accesses are pulses taken on the rising edge of core_clk.
// Notes: Inputs change 5 ns after the rising edge to avoid races.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  mismatches++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module parallel_serial_ext_setup_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic config_state = 1'b1;
  logic [7:0] config_index_register = 8'h04;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_wdata = 8'h00;
  logic printer_mode = 1'b0;
  logic [2:0] ecr_mode = 3'h1;
  logic ext_four_drive = 1'b0;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  ext_setup_pkg::setup_s setup;
  ext_setup_pkg::port_op_e port_op;
  logic epp_revision_select;
  logic [3:0] port1_divisor;
  logic [3:0] port2_divisor;
  logic port1_baud_tick;
  logic port2_baud_tick;
  logic four_drive_needed;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] d;
  logic v;
  int n;
  always #25 core_clk = ~core_clk;
  parallel_serial_ext_setup uut (.core_clk(core_clk), .reset_n(reset_n),
    .config_state(config_state), .config_index_register(config_index_register),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata),
    .printer_mode(printer_mode), .ecr_mode(ecr_mode),
    .ext_four_drive(ext_four_drive), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .setup(setup), .port_op(port_op),
    .epp_revision_select(epp_revision_select), .port1_divisor(port1_divisor),
    .port2_divisor(port2_divisor), .port1_baud_tick(port1_baud_tick),
    .port2_baud_tick(port2_baud_tick), .four_drive_needed(four_drive_needed));
  // ****************************************
  // Bus tasks
  // ****************************************
  task step;
    @(posedge core_clk);
    #5;
  endtask
  task wr(input logic [7:0] x);
    step();
    cfg_wr = 1'b1;
    cfg_wdata = x;
    step();
    cfg_wr = 1'b0;
    step();
    step();
  endtask
  task rd;
    step();
    cfg_rd = 1'b1;
    step();
    cfg_rd = 1'b0;
    d = cfg_rdata;
    v = cfg_rvalid;
  endtask
  // Counts the clocks between two ticks; a hung prescaler gives 40.
  task gap(input logic s);
    int k;
    for (k = 0; k < 40 && (s ? port2_baud_tick : port1_baud_tick) !== 1'b1;
      k++) step();
    n = 0;
    do begin
      step();
      n++;
    end while ((s ? port2_baud_tick : port1_baud_tick) !== 1'b1 && n < 40);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    `CHK(setup, 7'h00)
    `CHK(port1_divisor, ext_setup_pkg::DIV_STD)
    rd();
    `CHK({v, d}, 9'h100)
  endtask
  task t_bit7;
    wr(8'hff);
    rd();
    `CHK({v, d}, 9'h17f)
    `CHK(setup, 7'h7f)
    `CHK(epp_revision_select, 1'b1)
    `CHK(port2_divisor, ext_setup_pkg::DIV_MIDI)
  endtask
  task t_modes;
    ext_setup_pkg::port_op_e exp_op [4];
    exp_op = '{ext_setup_pkg::PORT_SPP, ext_setup_pkg::PORT_EPP,
      ext_setup_pkg::PORT_ECP, ext_setup_pkg::PORT_ECP};
    for (int i = 0; i < 4; i++) begin
      wr(8'(i * 5));
      `CHK(setup.floppy_route, 2'(i))
      `CHK(port_op, exp_op[i])
      `CHK(four_drive_needed, 1'(i >= 2))
    end
    wr(8'h02);
    ecr_mode = 3'h4;
    step();
    step();
    `CHK(port_op, ext_setup_pkg::PORT_ECP)
    ecr_mode = 3'h0;
    step();
    step();
    `CHK(port_op, ext_setup_pkg::PORT_SPP)
    wr(8'h0f);
    ext_four_drive = 1'b1;
    ecr_mode = 3'h4;
    step();
    step();
    `CHK(four_drive_needed, 1'b0)
    `CHK(port_op, ext_setup_pkg::PORT_EPP)
    ecr_mode = 3'h0;
    step();
    step();
    `CHK(port_op, ext_setup_pkg::PORT_SPP)
    printer_mode = 1'b1;
    step();
    step();
    `CHK(port_op, ext_setup_pkg::PORT_PRINTER)
    printer_mode = 1'b0;
  endtask
  task t_refuse;
    wr(8'h22);
    config_state = 1'b0;
    wr(8'h55);
    rd();
    `CHK({v, d}, 9'h000)
    config_state = 1'b1;
    config_index_register = 8'h05;
    wr(8'h55);
    rd();
    `CHK({v, d}, 9'h000)
    config_index_register = 8'h04;
    rd();
    `CHK({v, d}, 9'h122)
  endtask
  task t_back;
    step();
    cfg_wr = 1'b1;
    cfg_wdata = 8'h9a;
    step();
    cfg_wr = 1'b0;
    cfg_rd = 1'b1;
    step();
    `CHK({cfg_rvalid, cfg_rdata}, 9'h11a)
    cfg_wr = 1'b1;
    cfg_wdata = 8'h33;
    step();
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    `CHK({cfg_rvalid, cfg_rdata}, 9'h11a)
    rd();
    `CHK({v, d}, 9'h133)
  endtask
  task t_rerst;
    reset_n = 1'b0;
    step();
    step();
    `CHK({setup, cfg_rvalid, cfg_rdata, port1_baud_tick, port2_baud_tick, four_drive_needed}, 19'h00000)
    `CHK({port1_divisor, port2_divisor, port_op}, 11'h6e9)
    reset_n = 1'b1;
    rd();
    `CHK({v, d}, 9'h100)
  endtask
  task t_baud;
    wr(8'h10);
    gap(1'b0);
    `CHK(n, 12)
    gap(1'b1);
    `CHK(n, 13)
  endtask
  // ****************************************
  // Control
  // ****************************************
  task final_report;
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge core_clk);
    #5 reset_n = 1'b1;
    t_reset();
    t_bit7();
    t_modes();
    t_refuse();
    t_back();
    t_baud();
    t_rerst();
    final_report();
  end
endmodule
`default_nettype wire
